/* rtl/pci_isa_bridge_pkg.sv */
// Constants for the bridge configuration register bank
`default_nettype none
package pci_isa_bridge_pkg;
  // ----------------------------------------
  // Configuration commands on cbe_n
  // ----------------------------------------
  localparam logic [3:0] CFG_READ_CMD = 4'h a;
  localparam logic [3:0] CFG_WRITE_CMD = 4'h b;
  localparam logic [2:0] CFG_FUNCTION = 3'h0;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] FUNC_CTRL_THREE_OFFSET = 8'h42;
  localparam logic [7:0] FUNC_CTRL_FOUR_OFFSET = 8'h43;
  localparam logic [7:0] RESET_CTRL_OFFSET = 8'h44;
  localparam logic [7:0] ISA_CLOCK_DIVIDER_OFFSET = 8'h50;
  localparam logic [7:0] ISA_RECOVERY_OFFSET = 8'h51;
  localparam logic [7:0] BIOS_ROM_CTRL_OFFSET = 8'h52;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] FUNC_CTRL_THREE_RESET = 8'h28;
  localparam logic [7:0] FUNC_CTRL_FOUR_RESET = 8'h46;
  localparam logic [7:0] RESET_CTRL_RESET = 8'h00;
  localparam logic [7:0] ISA_CLOCK_DIVIDER_RESET = 8'h43;
  localparam logic [7:0] ISA_RECOVERY_RESET = 8'h43;
  localparam logic [7:0] BIOS_ROM_CTRL_RESET = 8'h04;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DELAYED_EN_BIT = 5;
  localparam int RETRY_EN_BIT = 1;
  localparam logic [7:0] FUNC_CTRL_FOUR_WRITE_MASK = 8'h7f;
  localparam int SYSTEM_RESET_BIT = 0;
  localparam int DIVISOR_WIDTH = 3;
  localparam int DIVISOR_LSB = 0;
  localparam int RECOVERY_WIDTH = 4;
  localparam int RECOVERY_8BIT_LSB = 4;
  localparam int RECOVERY_16BIT_LSB = 0;
  localparam int ROM_SIZE_BIT = 2;
  // ----------------------------------------
  // BIOS window bases
  // ----------------------------------------
  localparam logic [31:0] ROM_BASE_1MB = 32'hfff0_0000;
  localparam logic [31:0] ROM_BASE_512K = 32'hfff8_0000;
  // Fixed recovery added to every programmed count
  localparam logic [4:0] RECOVERY_FIXED_CLOCKS = 5'h01;
endpackage
`default_nettype wire

/* rtl/isa_clock_gen.sv */
// ISA clock enable divider
`default_nettype none
module isa_clock_gen #(
  parameter int DIV_WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [DIV_WIDTH-1:0] divisor,
  output logic clock_enable,
  output logic clock_level
);
  logic [DIV_WIDTH-1:0] count;
  logic [DIV_WIDTH-1:0] next_count;
  logic next_clock_enable;
  logic next_clock_level;

  // ----------------------------------------
  // Divide by divisor plus one
  // ----------------------------------------
  always_comb
  begin
    next_clock_enable = 1'b0;
    if (count >= divisor)
    begin
      next_count = '0;
      next_clock_enable = 1'b1;
    end
    else
    begin
      next_count = count + 1'b1;
    end
    next_clock_level = (next_count <= (divisor >> 1));
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count <= '0;
      clock_enable <= 1'b0;
      clock_level <= 1'b0;
    end
    else
    begin
      count <= next_count;
      clock_enable <= next_clock_enable;
      clock_level <= next_clock_level;
    end
  end
endmodule
`default_nettype wire

/* rtl/pci_isa_bridge_config_regs.sv */
// Configuration register bank of the bridge, reached by PCI configuration cycles
//
// Behaviour
// (R1) With its buffer not empty, the target answers with retry only while the retry-enable bit is one.
// (R2) The retry-enable bit counts only while the delayed-transaction bit of the third control register is set.
// (R3) The delayed-transaction bit allows delayed transactions when one and forbids them when zero.
// (R4) The fourth control register resets to 46h and its bit 7 is reserved, kept at zero.
// (R5) Software keeps internal-use bits by read-modify-write; these bits are stored and read back.
// (R6) A bit of the reset control register starts a system-wide reset for power-up clock setup.
// (R7) The ISA clock is the PCI clock divided by the programmed divisor plus one.
// (R8) The ISA clock divider register resets to 43h.
// (R9) One recovery field adds its count of ISA clocks after 8-bit cycles on top of one fixed clock.
// (R10) The other recovery field does the same for 16-bit cycles.
// (R11) The isa_recovery_control resets to 43h.
// (R12) The ROM control register selects a 512K or 1MB BIOS window at the top of memory.
// (R13) Registers are read and written by configuration cycles to this function, byte lane by byte lane.
`default_nettype none
module pci_isa_bridge_config_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic idsel,
  input wire logic [3:0] cbe_n,
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe_n,
  output logic devsel_n,
  output logic devsel_oe_n,
  output logic trdy_n,
  output logic trdy_oe_n,
  output logic stop_n,
  output logic stop_oe_n,
  input wire logic buffer_not_empty,
  output logic target_retry,
  output logic delayed_transactions_enable,
  output logic system_reset,
  output logic isa_clock_enable,
  output logic isa_clock,
  input wire logic isa_cycle_end,
  input wire logic isa_cycle_16bit,
  output logic isa_recovery_busy,
  input wire logic [31:0] mem_address,
  output logic bios_rom_hit
);
  typedef enum logic [1:0] {st_idle, st_claim, st_data, st_release} cfg_state_t;

  cfg_state_t state;
  cfg_state_t next_state;
  logic cfg_write;
  logic next_cfg_write;
  logic [5:0] dword_index;
  logic [5:0] next_dword_index;
  logic [31:0] next_ad_out;

  logic [7:0] func_ctrl_three;
  logic [7:0] pci_function_control_four;
  logic [7:0] reset_control;
  logic [7:0] isa_clock_divider;
  logic [7:0] isa_recovery_control;
  logic [7:0] bios_rom_control;
  logic [7:0] next_func_ctrl_three;
  logic [7:0] next_pci_function_control_four;
  logic [7:0] next_reset_control;
  logic [7:0] next_isa_clock_divider;
  logic [7:0] next_isa_recovery_control;
  logic [7:0] next_bios_rom_control;
  logic next_system_reset;

  logic [4:0] recovery_count;
  logic [4:0] next_recovery_count;
  logic next_bios_rom_hit;
  logic next_target_retry;
  logic [31:0] read_word;

  // ----------------------------------------
  // Read data assembly
  // ----------------------------------------
  function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [7:0] fc3, input logic [7:0] fc4,
                                           input logic [7:0] rc, input logic [7:0] dv, input logic [7:0] rv,
                                           input logic [7:0] rom);
    logic [7:0] value;
    value = 8'h00;
    case (addr)
      pci_isa_bridge_pkg::FUNC_CTRL_THREE_OFFSET: value = fc3;
      pci_isa_bridge_pkg::FUNC_CTRL_FOUR_OFFSET: value = fc4 & pci_isa_bridge_pkg::FUNC_CTRL_FOUR_WRITE_MASK;
      pci_isa_bridge_pkg::RESET_CTRL_OFFSET: value = rc;
      pci_isa_bridge_pkg::ISA_CLOCK_DIVIDER_OFFSET: value = dv;
      pci_isa_bridge_pkg::ISA_RECOVERY_OFFSET: value = rv;
      pci_isa_bridge_pkg::BIOS_ROM_CTRL_OFFSET: value = rom;
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  always_comb
  begin
    read_word = 32'h0000_0000;
    for (int lane = 0; lane < 4; lane++)
    begin
      read_word[lane*8 +: 8] = read_byte({dword_index, lane[1:0]}, func_ctrl_three, pci_function_control_four,
                                         reset_control, isa_clock_divider, isa_recovery_control,
                                         bios_rom_control); // R5
    end
  end

  // ----------------------------------------
  // Configuration target sequencing
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_cfg_write = cfg_write;
    next_dword_index = dword_index;
    next_ad_out = ad_out;
    case (state)
      st_idle:
      begin
        if (!frame_n && idsel && ad_in[1:0] == 2'b00 && ad_in[10:8] == pci_isa_bridge_pkg::CFG_FUNCTION &&
            (cbe_n == pci_isa_bridge_pkg::CFG_READ_CMD || cbe_n == pci_isa_bridge_pkg::CFG_WRITE_CMD)) // R13
        begin
          next_state = st_claim;
          next_cfg_write = (cbe_n == pci_isa_bridge_pkg::CFG_WRITE_CMD);
          next_dword_index = ad_in[7:2];
        end
      end
      st_claim:
      begin
        next_ad_out = read_word;
        next_state = st_data;
      end
      st_data:
      begin
        if (!irdy_n)
        begin
          next_state = st_release;
        end
      end
      st_release:
      begin
        next_state = st_idle;
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
  end

  // ----------------------------------------
  // Register writes by byte lane
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] addr;
    logic [7:0] data;
    addr = 8'h00;
    data = 8'h00;
    next_func_ctrl_three = func_ctrl_three;
    next_pci_function_control_four = pci_function_control_four;
    next_reset_control = reset_control;
    next_isa_clock_divider = isa_clock_divider;
    next_isa_recovery_control = isa_recovery_control;
    next_bios_rom_control = bios_rom_control;
    next_system_reset = 1'b0;
    if (state == st_data && !irdy_n && cfg_write)
    begin
      for (int lane = 0; lane < 4; lane++)
      begin
        addr = {dword_index, lane[1:0]};
        data = ad_in[lane*8 +: 8];
        if (!cbe_n[lane]) // R13
        begin
          case (addr)
            pci_isa_bridge_pkg::FUNC_CTRL_THREE_OFFSET: next_func_ctrl_three = data; // R3
            pci_isa_bridge_pkg::FUNC_CTRL_FOUR_OFFSET:
              next_pci_function_control_four = data & pci_isa_bridge_pkg::FUNC_CTRL_FOUR_WRITE_MASK; // R4
            pci_isa_bridge_pkg::RESET_CTRL_OFFSET:
            begin
              // Reset bit self-clears so the bank reads idle after the pulse
              next_system_reset = data[pci_isa_bridge_pkg::SYSTEM_RESET_BIT]; // R6
              next_reset_control = data;
              next_reset_control[pci_isa_bridge_pkg::SYSTEM_RESET_BIT] = 1'b0;
            end
            pci_isa_bridge_pkg::ISA_CLOCK_DIVIDER_OFFSET: next_isa_clock_divider = data; // R7
            pci_isa_bridge_pkg::ISA_RECOVERY_OFFSET: next_isa_recovery_control = data; // R9
            pci_isa_bridge_pkg::BIOS_ROM_CTRL_OFFSET: next_bios_rom_control = data; // R12
            default:
            begin
              next_system_reset = next_system_reset;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Retry, recovery and ROM window
  // ----------------------------------------
  always_comb
  begin
    logic [4:0] programmed;
    programmed = 5'h00;
    next_target_retry = buffer_not_empty &&
                        func_ctrl_three[pci_isa_bridge_pkg::DELAYED_EN_BIT] && // R2
                        pci_function_control_four[pci_isa_bridge_pkg::RETRY_EN_BIT]; // R1
    if (isa_cycle_16bit)
    begin
      programmed = {1'b0, isa_recovery_control[pci_isa_bridge_pkg::RECOVERY_16BIT_LSB +:
                                                pci_isa_bridge_pkg::RECOVERY_WIDTH]}; // R10
    end
    else
    begin
      programmed = {1'b0, isa_recovery_control[pci_isa_bridge_pkg::RECOVERY_8BIT_LSB +:
                                                pci_isa_bridge_pkg::RECOVERY_WIDTH]}; // R9
    end
    next_recovery_count = recovery_count;
    if (isa_cycle_end)
    begin
      next_recovery_count = programmed + pci_isa_bridge_pkg::RECOVERY_FIXED_CLOCKS; // R9 R10
    end
    else if (isa_clock_enable && recovery_count != 5'h00)
    begin
      next_recovery_count = recovery_count - 5'h01;
    end
    if (bios_rom_control[pci_isa_bridge_pkg::ROM_SIZE_BIT])
    begin
      next_bios_rom_hit = (mem_address >= pci_isa_bridge_pkg::ROM_BASE_1MB); // R12
    end
    else
    begin
      next_bios_rom_hit = (mem_address >= pci_isa_bridge_pkg::ROM_BASE_512K); // R12
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= st_idle;
      cfg_write <= 1'b0;
      dword_index <= 6'h00;
      ad_out <= 32'h0000_0000;
      func_ctrl_three <= pci_isa_bridge_pkg::FUNC_CTRL_THREE_RESET;
      pci_function_control_four <= pci_isa_bridge_pkg::FUNC_CTRL_FOUR_RESET; // R4
      reset_control <= pci_isa_bridge_pkg::RESET_CTRL_RESET;
      isa_clock_divider <= pci_isa_bridge_pkg::ISA_CLOCK_DIVIDER_RESET; // R8
      isa_recovery_control <= pci_isa_bridge_pkg::ISA_RECOVERY_RESET; // R11
      bios_rom_control <= pci_isa_bridge_pkg::BIOS_ROM_CTRL_RESET;
      system_reset <= 1'b0;
      recovery_count <= 5'h00;
      target_retry <= 1'b0;
      bios_rom_hit <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cfg_write <= next_cfg_write;
      dword_index <= next_dword_index;
      ad_out <= next_ad_out;
      func_ctrl_three <= next_func_ctrl_three;
      pci_function_control_four <= next_pci_function_control_four;
      reset_control <= next_reset_control;
      isa_clock_divider <= next_isa_clock_divider;
      isa_recovery_control <= next_isa_recovery_control;
      bios_rom_control <= next_bios_rom_control;
      system_reset <= next_system_reset;
      recovery_count <= next_recovery_count;
      target_retry <= next_target_retry;
      bios_rom_hit <= next_bios_rom_hit;
    end
  end

  // ----------------------------------------
  // Bus pin drive
  // ----------------------------------------
  assign devsel_n = !(state == st_claim || state == st_data);
  assign devsel_oe_n = (state == st_idle);
  assign trdy_n = (state != st_data);
  assign trdy_oe_n = (state == st_idle);
  assign stop_n = 1'b1;
  assign stop_oe_n = (state == st_idle);
  assign ad_oe_n = !(state == st_data && !cfg_write);
  assign delayed_transactions_enable = func_ctrl_three[pci_isa_bridge_pkg::DELAYED_EN_BIT]; // R3
  assign isa_recovery_busy = (recovery_count != 5'h00);

  // ----------------------------------------
  // ISA clock
  // ----------------------------------------
  isa_clock_gen #(
    .DIV_WIDTH(pci_isa_bridge_pkg::DIVISOR_WIDTH)
  ) u_isa_clock_gen (
    .clk(clk),
    .reset(reset),
    .divisor(isa_clock_divider[pci_isa_bridge_pkg::DIVISOR_LSB +: pci_isa_bridge_pkg::DIVISOR_WIDTH]), // R7
    .clock_enable(isa_clock_enable),
    .clock_level(isa_clock)
  );
endmodule
`default_nettype wire

/* test/pci_host_model.sv */
// PCI initiator model issuing single-phase configuration cycles
`default_nettype none
module pci_host_model (
  input wire logic clk,
  input wire logic trdy_n,
  input wire logic [31:0] ad_out,
  output logic frame_n,
  output logic irdy_n,
  output logic idsel,
  output logic [3:0] cbe_n,
  output logic [31:0] host_ad
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    frame_n = 1'b1;
    irdy_n = 1'b1;
    idsel = 1'b0;
    cbe_n = 4'hf;
    host_ad = 32'h0000_0000;
  end
  // Entered and left at a falling edge; one byte lane per cycle
  task automatic cfg(input logic wr, input logic sel, input logic [7:0] off, input logic [7:0] wd,
                     output logic [7:0] rd, output logic ok);
    int k;
    ok = 1'b0;
    frame_n = 1'b0;
    idsel = sel;
    cbe_n = wr ? pci_isa_bridge_pkg::CFG_WRITE_CMD : pci_isa_bridge_pkg::CFG_READ_CMD;
    host_ad = {24'h00_0000, off[7:2], 2'h0};
    @(negedge clk);
    frame_n = 1'b1;
    idsel = 1'b0;
    irdy_n = 1'b0;
    cbe_n = ~(4'h1 << off[1:0]);
    host_ad = wr ? ({24'h00_0000, wd} << (8 * off[1:0])) : ~host_ad;
    for (k = 0; k < 8 && !ok; k++)
    begin
      @(negedge clk);
      ok = (trdy_n === 1'b0);
    end
    rd = ad_out[8 * off[1:0] +: 8];
    @(negedge clk);
    irdy_n = 1'b1;
    cbe_n = 4'hf;
    // Released bus shows a changed pattern, never the last value
    host_ad = ~host_ad;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* test/pci_isa_bridge_config_regs_checker.sv */
// Port-level assertions for the bridge configuration register bank
`default_nettype none
module pci_isa_bridge_config_regs_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic idsel,
  input wire logic [3:0] cbe_n,
  input wire logic [31:0] ad_in,
  input wire logic ad_oe_n,
  input wire logic devsel_n,
  input wire logic devsel_oe_n,
  input wire logic trdy_n,
  input wire logic trdy_oe_n,
  input wire logic stop_n,
  input wire logic stop_oe_n,
  input wire logic buffer_not_empty,
  input wire logic target_retry,
  input wire logic delayed_transactions_enable,
  input wire logic system_reset,
  input wire logic isa_clock_enable,
  input wire logic isa_clock,
  input wire logic isa_cycle_end,
  input wire logic isa_recovery_busy,
  input wire logic [31:0] mem_address,
  input wire logic bios_rom_hit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence cfg_taken;
    devsel_oe_n && !frame_n && idsel && ad_in[1:0] == 2'h0 && ad_in[10:8] == 3'h0 &&
      (cbe_n == pci_isa_bridge_pkg::CFG_READ_CMD || cbe_n == pci_isa_bridge_pkg::CFG_WRITE_CMD);
  endsequence
  sequence claim_then_data;
    ##1 (!devsel_n && trdy_n && !devsel_oe_n) ##1 !trdy_n;
  endsequence
  a_cfg_claim_order: assert property (cfg_taken |-> claim_then_data)
    else $error("configuration cycle not claimed in order");
  a_read_drives_ad: assert property ((cfg_taken ##0 cbe_n == pci_isa_bridge_pkg::CFG_READ_CMD)
    |-> ##2 !ad_oe_n)
    else $error("read data not driven");
  a_no_claim_unselected: assert property (devsel_oe_n && !idsel |=> devsel_oe_n)
    else $error("claimed without select");
  a_release_after_data: assert property (!trdy_n && !irdy_n |=> (trdy_n && devsel_n && !devsel_oe_n)
    ##1 devsel_oe_n)
    else $error("bad release after data phase");
  a_retry_needs_buffer: assert property (!buffer_not_empty |=> !target_retry)
    else $error("retry without buffered data");
  a_retry_needs_delayed: assert property (!delayed_transactions_enable |=> !target_retry)
    else $error("retry while delayed transactions off");
  a_sysreset_one_pulse: assert property (system_reset |=> !system_reset)
    else $error("system reset longer than one cycle");
  a_recovery_starts: assert property (isa_cycle_end |=> isa_recovery_busy)
    else $error("recovery not started");
  a_recovery_holds: assert property (isa_recovery_busy && !isa_clock_enable |=> isa_recovery_busy)
    else $error("recovery ended without ISA clock");
  a_rom_below_window: assert property (mem_address < pci_isa_bridge_pkg::ROM_BASE_1MB |=> !bios_rom_hit)
    else $error("ROM hit below window");
  a_rom_top_window: assert property (mem_address >= pci_isa_bridge_pkg::ROM_BASE_512K |=> bios_rom_hit)
    else $error("ROM miss in top window");
  a_oe_follow_devsel: assert property (stop_n && trdy_oe_n == devsel_oe_n && stop_oe_n == devsel_oe_n)
    else $error("target enables disagree");
  a_isa_clock_high: assert property (isa_clock_enable |-> isa_clock)
    else $error("ISA clock low at enable");
endmodule
bind pci_isa_bridge_config_regs pci_isa_bridge_config_regs_checker i_checker (.*);
`default_nettype wire

/* test/pci_isa_bridge_config_regs_tb.sv */
// Self-checking testbench for the bridge configuration register bank
`default_nettype none
module pci_isa_bridge_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic frame_n, irdy_n, idsel, ad_oe_n, devsel_n, devsel_oe_n, trdy_n, trdy_oe_n, stop_n, stop_oe_n;
  logic buffer_not_empty, target_retry, delayed_transactions_enable, system_reset, isa_clock_enable;
  logic isa_clock, isa_cycle_end, isa_cycle_16bit, isa_recovery_busy, bios_rom_hit;
  logic [3:0] cbe_n;
  logic [31:0] ad_in, ad_out, host_ad, mem_address;
  int miscompares = 0;
  int comparisons = 0;
  int resets_seen = 0;
  always #50 clk = ~clk;
  assign ad_in = ad_oe_n ? host_ad : ad_out;
  always @(posedge clk)
    if (system_reset === 1'b1)
      resets_seen++;
  pci_isa_bridge_config_regs i_pci_isa_bridge_config_regs (.*);
  pci_host_model i_pci_host_model (.*);
  task automatic test_done;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [7:0] off, input logic [7:0] wd, output logic [7:0] rd);
    logic ok;
    i_pci_host_model.cfg(wr, 1'b1, off, wd, rd, ok);
    if (ok !== 1'b1)
    begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic rd_check(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] rd;
    access(1'b0, off, 8'h00, rd);
    check(rd, exp);
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] rd;
    access(1'b1, off, d, rd);
  endtask
  // Falling edges up to and including the next ISA clock enable
  task automatic gap(output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (isa_clock_enable !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic t_reset_values;
    rd_check(8'h42, 8'h28);
    rd_check(8'h43, 8'h46);
    rd_check(8'h44, 8'h00);
    rd_check(8'h50, 8'h43);
    rd_check(8'h51, 8'h43);
    rd_check(8'h52, 8'h04);
    rd_check(8'h45, 8'h00);
    check({7'h0, delayed_transactions_enable}, 8'h01);
    $display("reset values done");
  endtask
  task automatic t_retry;
    logic [7:0] v;
    buffer_not_empty = 1'b1;
    access(1'b0, 8'h43, 8'h00, v);
    repeat (2) @(negedge clk);
    check({7'h0, target_retry}, 8'h01);
    wr(8'h42, 8'h08);
    repeat (2) @(negedge clk);
    check({7'h0, delayed_transactions_enable}, 8'h00);
    check({7'h0, target_retry}, 8'h00);
    wr(8'h42, 8'h28);
    wr(8'h43, v & 8'hfd);
    repeat (2) @(negedge clk);
    check({7'h0, target_retry}, 8'h00);
    wr(8'h43, v | 8'h80);
    rd_check(8'h43, 8'h46);
    buffer_not_empty = 1'b0;
    $display("retry control done");
  endtask
  task automatic t_divider;
    int n;
    gap(n);
    gap(n);
    check(n[7:0], 8'h04);
    wr(8'h50, 8'h45);
    gap(n);
    gap(n);
    check(n[7:0], 8'h06);
    $display("clock divider done");
  endtask
  task automatic rec(input logic b16, input logic [7:0] exp);
    int n;
    int k;
    n = 0;
    isa_cycle_16bit = b16;
    isa_cycle_end = 1'b1;
    @(negedge clk);
    isa_cycle_end = 1'b0;
    for (k = 0; k < 100 && isa_recovery_busy === 1'b1; k++)
    begin
      if (isa_clock_enable === 1'b1)
        n++;
      @(negedge clk);
    end
    if (k == 100)
    begin
      miscompares++;
      test_done();
    end
    check(n[7:0], exp);
  endtask
  task automatic t_recovery;
    rec(1'b0, 8'h05);
    rec(1'b1, 8'h04);
    wr(8'h51, 8'h21);
    rec(1'b0, 8'h03);
    rec(1'b1, 8'h02);
    $display("recovery done");
  endtask
  task automatic rom(input logic [31:0] a, input logic exp);
    mem_address = a;
    @(negedge clk);
    @(negedge clk);
    check({7'h0, bios_rom_hit}, {7'h0, exp});
  endtask
  task automatic t_rom;
    rom(32'hfff4_0000, 1'b1);
    rom(32'hffef_ffff, 1'b0);
    wr(8'h52, 8'h00);
    rom(32'hfff4_0000, 1'b0);
    rom(32'hfff8_0000, 1'b1);
    rom(32'hffff_ffff, 1'b1);
    $display("rom window done");
  endtask
  // Cycle without select must not be claimed nor land
  task automatic t_refused;
    logic [7:0] rd;
    logic ok;
    i_pci_host_model.cfg(1'b1, 1'b0, 8'h52, 8'h04, rd, ok);
    check({7'h0, ok}, 8'h00);
    rd_check(8'h52, 8'h00);
    $display("refused cycle done");
  endtask
  task automatic t_reset_again;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    rd_check(8'h50, 8'h43);
    rd_check(8'h51, 8'h43);
    rd_check(8'h52, 8'h04);
    $display("mid-run reset done");
  endtask
  task automatic t_sysreset;
    check(resets_seen[7:0], 8'h00);
    wr(8'h44, 8'h01);
    repeat (4) @(negedge clk);
    check(resets_seen[7:0], 8'h01);
    rd_check(8'h44, 8'h00);
    $display("system reset done");
  endtask
  initial
  begin
    buffer_not_empty = 1'b0;
    isa_cycle_end = 1'b0;
    isa_cycle_16bit = 1'b0;
    mem_address = 32'h0000_0000;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    t_reset_values();
    t_retry();
    t_divider();
    t_recovery();
    t_rom();
    t_refused();
    t_sysreset();
    t_reset_again();
    test_done();
  end
endmodule
`default_nettype wire
